//--- verilog/cgu_pkg.sv
// Constants, field layouts and carrier types of the clock generation unit.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
package cgu_pkg;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ          = 50_000_000;
  localparam int CLK_PERIOD_NS   = 20;
  localparam int IRG_SLOW_HZ     = 243_000;
  localparam int IRG_FAST_HZ     = 8_000_000;
  localparam int DCO_MIN_HZ      = 8_000_000;
  localparam int DCO_MAX_HZ      = 40_000_000;
  localparam int EXT_LOSS_NS     = 40_960;
  localparam int SLOW_CYC        = CLK_HZ / IRG_SLOW_HZ;
  localparam int FAST_HALF_CYC   = CLK_HZ / (2 * IRG_FAST_HZ);
  localparam int EXT_LOSS_CYC    = EXT_LOSS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] DCO_WORD_MIN = 16'(longint'(DCO_MIN_HZ) * 65536 / CLK_HZ);
  localparam logic [15:0] DCO_WORD_MAX = 16'(longint'(DCO_MAX_HZ) * 65536 / CLK_HZ);
  localparam int DCO_GAIN_SH     = 6;
  localparam int PRESCALE_LOW    = 64;
  localparam int PRESCALE_HIGH   = 1;
  localparam logic [2:0] EXT_GOOD_EDGES = 3'h4;
  localparam logic [2:0] LOCK_WINDOWS   = 3'h4;
  localparam int LOCK_TOL        = 1;
  localparam int UNLOCK_TOL      = 4;
  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MULT = 4'h1;
  localparam logic [3:0] ADDR_DIV  = 4'h2;
  localparam logic [3:0] ADDR_FILT = 4'h3;
  localparam logic [3:0] ADDR_TRIM = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h5;
  localparam int CTRL_CLOCK_MODE_SELECT_LO  = 0;
  localparam int CTRL_HGO      = 2;
  localparam int CTRL_RANGE    = 3;
  localparam int CTRL_LOCD     = 4;
  localparam int CTRL_LOSS_RST = 5;
  localparam int STAT_LOCKED   = 0;
  localparam int STAT_EXT_OK   = 1;
  localparam int STAT_LOL      = 2;
  localparam int STAT_LOC      = 3;
  localparam int STAT_SRC_EXT  = 4;
  localparam int STAT_OFF      = 5;
  localparam logic [1:0] CLOCK_MODE_SELECT_SCM = 2'h0;
  localparam logic [1:0] CLOCK_MODE_SELECT_FEI = 2'h1;
  localparam logic [1:0] CLOCK_MODE_SELECT_FBE = 2'h2;
  localparam logic [1:0] CLOCK_MODE_SELECT_FEE = 2'h3;
  localparam logic [7:0]  MULT_RST = 8'h20;
  localparam logic [15:0] DCO_RST  = 16'h4000;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF, ST_SCM, ST_FEI_UNL, ST_FEI_LCK, ST_FBE, ST_FEE_UNL, ST_FEE_LCK
  } cgu_state_t;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } cgu_bus_t;
  typedef struct packed {
    logic clock_gen_output;
    logic loop_multiplied_clock;
    logic external_reference_clock;
    logic debug_local_clock;
    logic fixed_freq_enable;
    logic rti_clock;
  } cgu_clk_t;
endpackage : cgu_pkg

//--- verilog/cgu_top.sv
// Clock generation unit: mode control, oscillator model, loop and clock select.
// Assumes ext_ref_in and stop_req are synchronous to ref_clk; every derived
// clock is registered; all but the external copy and the enable pulse are levels that toggle on one-cycle enables.
//
// Functional notes
// - Reset starts in self-clocked mode immediately.
// - Off mode holds the output clock static.
// - Self-clocked oscillator free-runs at filter value.
// - Internal loop multiplies the internal reference.
// - Loop modes pass unlocked, then locked.
// - Bypass mode drives output from external clock.
// - External loop multiplies the external reference.
// - Post divider selects divide 1 to 128.
// - Loop updates clamp oscillator word to 8-40 MHz.
// - Clock or lock loss raises reset or interrupt.
// - Never switch to a source not running.
// - Output moves to loop after lock.
// - Oscillator setting kept through stop.
// - Lost reference freezes oscillator frequency.
// - Status shows lock and loss of lock.
// - External reference monitored for validity.
// - Internal fast and trimmable slow references.
// - Periodic interrupt clock paced by the trimmed slow reference.
// - High gain select picks oscillator amplitude.
// - Range select picks low or high crystal.
// - External square wave passed to clock path.
// - Select block drives loop, ext, debug, enable.
// - Mode field codes 00 01 10 11.
// - Prescale 64 in low range, 1 high.
`timescale 1ns/1ps
module cgu_top
  import cgu_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire cgu_bus_t    bus,
  output logic      [15:0] bus_rdata,
  input  wire logic        ext_ref_in,
  input  wire logic        stop_req,
  output cgu_clk_t         clocks,
  output logic             osc_high_gain,
  output logic             osc_high_range,
  output logic             osc_enable,
  output logic             loss_reset_req,
  output logic             loss_irq
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    cgu_state_t  st;
    logic [1:0]  clock_mode_select;
    logic        high_gain_select;
    logic        range_hi;
    logic        locd;
    logic        rst_on_loss;
    logic        cfg_done;
    logic        ext_rsv;
    logic [7:0]  mult;
    logic [2:0]  div_sel;
    logic [7:0]  trim;
    logic [15:0] dco_word;
    logic [15:0] dco_acc;
    logic [8:0]  slow_cnt;
    logic [1:0]  fast_cnt;
    logic        ext_prev;
    logic [11:0] ext_idle;
    logic [2:0]  ext_good;
    logic        ext_valid;
    logic [15:0] win_cnt;
    logic [2:0]  lock_run;
    logic        lol_flag;
    logic        loc_flag;
    logic        src_ext;
    logic [6:0]  div_cnt;
    logic        osc_en;
    logic        loss_rst;
    logic        loss_int;
    logic [15:0] rdata;
    cgu_clk_t    clk;
  } cgu_regs_t;

  cgu_regs_t s_reg;
  cgu_regs_t s_next;

  logic               ext_rise;
  logic               ext_edge;
  logic               slow_tick;
  logic               fast_tick;
  logic               dco_carry;
  logic               dco_tick;
  logic               in_fei;
  logic               in_fee;
  logic               in_lck;
  logic               win_end;
  logic [15:0]        target;
  logic signed [17:0] err;
  logic signed [17:0] aerr;
  logic signed [19:0] wsum;
  logic               lock_ok;
  logic               lock_lost;
  logic               loc_evt;
  logic               clr_lol;
  logic               clr_loc;
  logic               want_ext;
  logic               src_tick;
  logic [6:0]         div_mask;
  logic [8:0]         slow_period;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.loss_rst = 1'b0;
    s_next.rdata = 16'h0000;
    clr_lol = 1'b0;
    clr_loc = 1'b0;
    in_fei = (s_reg.st == ST_FEI_UNL) || (s_reg.st == ST_FEI_LCK);
    in_fee = (s_reg.st == ST_FEE_UNL) || (s_reg.st == ST_FEE_LCK);
    in_lck = (s_reg.st == ST_FEI_LCK) || (s_reg.st == ST_FEE_LCK);

    // Register writes. Oscillator settings are write-once so a running crystal is never retuned.
    if (bus.wr) begin
      case (bus.addr)
        ADDR_CTRL: begin
          if (!s_reg.cfg_done) begin
            s_next.high_gain_select = bus.wdata[CTRL_HGO];
            s_next.range_hi = bus.wdata[CTRL_RANGE];
            s_next.ext_rsv = bus.wdata[CTRL_CLOCK_MODE_SELECT_LO+1];
          end
          s_next.cfg_done = 1'b1;
          if (!bus.wdata[CTRL_CLOCK_MODE_SELECT_LO+1] || s_next.ext_rsv) begin
            s_next.clock_mode_select = bus.wdata[CTRL_CLOCK_MODE_SELECT_LO+:2];
          end
          s_next.locd = bus.wdata[CTRL_LOCD];
          s_next.rst_on_loss = bus.wdata[CTRL_LOSS_RST];
        end
        ADDR_MULT: s_next.mult = bus.wdata[7:0];
        ADDR_DIV:  s_next.div_sel = bus.wdata[2:0];
        ADDR_FILT: s_next.dco_word = bus.wdata;
        ADDR_TRIM: s_next.trim = bus.wdata[7:0];
        ADDR_STAT: begin
          clr_lol = bus.wdata[STAT_LOL];
          clr_loc = bus.wdata[STAT_LOC];
        end
        default: ;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL: s_next.rdata = {10'h000, s_reg.rst_on_loss, s_reg.locd, s_reg.range_hi, s_reg.high_gain_select, s_reg.clock_mode_select};
        ADDR_MULT: s_next.rdata = {8'h00, s_reg.mult};
        ADDR_DIV:  s_next.rdata = {13'h0000, s_reg.div_sel};
        ADDR_FILT: s_next.rdata = s_reg.dco_word;
        ADDR_TRIM: s_next.rdata = {8'h00, s_reg.trim};
        ADDR_STAT: s_next.rdata = {10'h000, s_reg.st == ST_OFF, s_reg.src_ext, s_reg.loc_flag,
                                   s_reg.lol_flag, s_reg.ext_valid, in_lck};
        default:   s_next.rdata = 16'h0000;
      endcase
    end

    // External reference: pass-through and activity monitor.
    ext_rise = ext_ref_in & ~s_reg.ext_prev;
    ext_edge = ext_ref_in ^ s_reg.ext_prev;
    s_next.ext_prev = ext_ref_in;
    s_next.clk.external_reference_clock = ext_ref_in & s_reg.ext_rsv;
    if (ext_edge) begin
      s_next.ext_idle = 12'h000;
      if (s_reg.ext_good != EXT_GOOD_EDGES) begin
        s_next.ext_good = s_reg.ext_good + 3'h1;
      end else begin
        s_next.ext_valid = 1'b1;
      end
    end else if (s_reg.ext_idle == 12'(EXT_LOSS_CYC)) begin
      s_next.ext_valid = 1'b0;
      s_next.ext_good = 3'h0;
    end else begin
      s_next.ext_idle = s_reg.ext_idle + 12'h001;
    end

    // Internal references; the slow one is trimmed and also paces the periodic interrupt.
    slow_period = 9'(SLOW_CYC) + {s_reg.trim[7], s_reg.trim};
    slow_tick = (s_reg.slow_cnt >= slow_period - 9'h001);
    s_next.slow_cnt = slow_tick ? 9'h000 : s_reg.slow_cnt + 9'h001;
    s_next.clk.rti_clock = s_reg.clk.rti_clock ^ slow_tick;
    fast_tick = (s_reg.fast_cnt == 2'(FAST_HALF_CYC - 1));
    s_next.fast_cnt = fast_tick ? 2'h0 : s_reg.fast_cnt + 2'h1;
    s_next.clk.debug_local_clock = s_reg.clk.debug_local_clock ^ fast_tick;

    // Oscillator: phase accumulator. Frozen in off mode so it restarts where it left off.
    {dco_carry, s_next.dco_acc} = {1'b0, s_reg.dco_acc} + {1'b0, s_reg.dco_word};
    if (s_reg.st == ST_OFF) begin
      s_next.dco_acc = s_reg.dco_acc;
    end
    dco_tick = dco_carry && (s_reg.st != ST_OFF);
    s_next.clk.loop_multiplied_clock = s_reg.clk.loop_multiplied_clock ^ dco_tick;

    // Loop: count oscillator ticks over one reference period and steer the word.
    win_end = in_fei ? slow_tick : (in_fee && ext_rise && s_reg.ext_valid);
    target = (in_fee && !s_reg.range_hi) ? 16'(s_reg.mult * PRESCALE_LOW)
                                         : 16'(s_reg.mult * PRESCALE_HIGH);
    err = $signed({2'b00, target}) - $signed({2'b00, s_reg.win_cnt});
    aerr = (err < 0) ? -err : err;
    wsum = $signed({4'h0, s_reg.dco_word}) + ($signed(20'(err)) <<< DCO_GAIN_SH);
    lock_ok = 1'b0;
    lock_lost = 1'b0;
    if (in_fei || in_fee) begin
      if (win_end) begin
        s_next.win_cnt = {15'h0000, dco_tick};
        if (wsum < $signed({4'h0, DCO_WORD_MIN})) begin
          s_next.dco_word = DCO_WORD_MIN;
        end else if (wsum > $signed({4'h0, DCO_WORD_MAX})) begin
          s_next.dco_word = DCO_WORD_MAX;
        end else begin
          s_next.dco_word = wsum[15:0];
        end
        if (aerr <= 18'sd1 * LOCK_TOL) begin
          s_next.lock_run = (s_reg.lock_run == LOCK_WINDOWS) ? s_reg.lock_run : s_reg.lock_run + 3'h1;
          lock_ok = !in_lck && (s_reg.lock_run == LOCK_WINDOWS - 3'h1);
        end else begin
          s_next.lock_run = 3'h0;
          lock_lost = in_lck && (aerr > 18'sd1 * UNLOCK_TOL);
        end
      end else begin
        s_next.win_cnt = s_reg.win_cnt + {15'h0000, dco_tick};
      end
    end else begin
      s_next.win_cnt = 16'h0000;
      s_next.lock_run = 3'h0;
    end

    // Mode control.
    if (s_reg.st == ST_OFF) begin
      if (!stop_req) begin
        s_next.st = ST_SCM;
      end
    end else if (stop_req) begin
      s_next.st = ST_OFF;
    end else begin
      case (s_reg.clock_mode_select)
        CLOCK_MODE_SELECT_SCM: s_next.st = ST_SCM;
        CLOCK_MODE_SELECT_FEI: begin
          if (!in_fei || lock_lost) begin
            s_next.st = ST_FEI_UNL;
          end else if (lock_ok) begin
            s_next.st = ST_FEI_LCK;
          end
        end
        CLOCK_MODE_SELECT_FBE: begin
          if (s_reg.ext_valid) begin
            s_next.st = ST_FBE;
          end
        end
        CLOCK_MODE_SELECT_FEE: begin
          if (!in_fee) begin
            if (s_reg.ext_valid) begin
              s_next.st = ST_FEE_UNL;
            end
          end else if (lock_lost) begin
            s_next.st = ST_FEE_UNL;
          end else if (lock_ok) begin
            s_next.st = ST_FEE_LCK;
          end
        end
        default: s_next.st = ST_SCM;
      endcase
    end
    s_next.osc_en = s_next.ext_rsv && (s_next.st != ST_OFF);

    // Loss monitoring; a new event wins over a clear in the same cycle.
    loc_evt = s_reg.ext_valid && !s_next.ext_valid && !s_reg.locd && ((s_reg.st == ST_FBE) || in_fee);
    s_next.lol_flag = lock_lost || (s_reg.lol_flag && !clr_lol);
    s_next.loc_flag = loc_evt || (s_reg.loc_flag && !clr_loc);
    s_next.loss_rst = s_reg.rst_on_loss && (lock_lost || loc_evt);
    s_next.loss_int = !s_reg.rst_on_loss && (s_next.lol_flag || s_next.loc_flag);

    // Clock select and post divider. A pending source change is taken only at the end
    // of a high phase, so neither phase is cut short; a dead external source is left while the output is low, in self-clocked or locked states.
    want_ext = (s_reg.st == ST_FBE) ? 1'b1 :
               ((s_reg.st == ST_SCM) || in_lck) ? 1'b0 : s_reg.src_ext;
    src_tick = (s_reg.st != ST_OFF) && (s_reg.src_ext ? ext_edge : dco_tick);
    div_mask = 7'((8'h01 << s_reg.div_sel) - 8'h01);
    if (src_tick) begin
      s_next.div_cnt = s_reg.div_cnt + 7'h01;
      if ((s_reg.div_cnt | ~div_mask) == 7'h7F) begin
        s_next.clk.clock_gen_output = ~s_reg.clk.clock_gen_output;
        s_next.div_cnt = 7'h00;
        if (s_reg.clk.clock_gen_output) begin
          s_next.src_ext = want_ext;
        end
      end
    end else if (!s_reg.clk.clock_gen_output && s_reg.src_ext && !s_reg.ext_valid) begin
      s_next.src_ext = want_ext;
      s_next.div_cnt = 7'h00;
    end
    s_next.clk.fixed_freq_enable = ext_rise && s_reg.ext_valid
                                   && ((s_reg.st == ST_FBE) || in_fee);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= ST_SCM;
      s_reg.mult <= MULT_RST;
      s_reg.dco_word <= DCO_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus_rdata      = s_reg.rdata;
  assign clocks         = s_reg.clk;
  assign osc_high_gain  = s_reg.high_gain_select;
  assign osc_high_range = s_reg.range_hi;
  assign osc_enable     = s_reg.osc_en;
  assign loss_reset_req = s_reg.loss_rst;
  assign loss_irq       = s_reg.loss_int;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_fei_unlocked;
    s_reg.st == ST_FEI_UNL;
  endsequence
  sequence s_fei_gain_lock;
    s_fei_unlocked ##1 (s_reg.st == ST_FEI_LCK);
  endsequence

  a_reset_to_scm: assert property ($fell(rst) |-> s_reg.st == ST_SCM)
    else $error("not self-clocked after reset");
  a_off_static: assert property ((s_reg.st == ST_OFF) ##1 (s_reg.st == ST_OFF)
    |-> $stable(s_reg.clk.clock_gen_output))
    else $error("output clock moved in off mode");
  a_off_word_kept: assert property ((s_reg.st == ST_OFF)[*2] |-> $stable(s_reg.dco_word))
    else $error("oscillator word lost in off mode");
  a_lock_path: assert property ($rose(s_reg.st == ST_FEI_LCK) |-> $past(s_reg.st) == ST_FEI_UNL)
    else $error("lock reached without unlocked state");
  a_lock_shown: assert property (s_fei_gain_lock
    |=> s_reg.rdata[STAT_LOCKED] || !($past(bus.rd) && ($past(bus.addr) == ADDR_STAT)))
    else $error("lock status not reported");
  a_bypass_valid: assert property ($rose(s_reg.st == ST_FBE) |-> $past(s_reg.ext_valid))
    else $error("bypass entered without valid reference");
  a_word_range: assert property ((s_reg.st != ST_SCM) && $changed(s_reg.dco_word) && !$past(bus.wr)
    |-> (s_reg.dco_word >= DCO_WORD_MIN) && (s_reg.dco_word <= DCO_WORD_MAX))
    else $error("oscillator word out of range");
  a_ref_loss_hold: assert property ((((s_reg.st == ST_FEE_UNL) || (s_reg.st == ST_FEE_LCK))
    && !s_reg.ext_valid && !bus.wr)
    |=> $stable(s_reg.dco_word))
    else $error("oscillator drifted without reference");
  a_loss_reset: assert property ($rose(s_reg.loc_flag) && s_reg.rst_on_loss |-> loss_reset_req)
    else $error("clock loss did not request reset");
  a_gain_once: assert property (s_reg.cfg_done && $past(s_reg.cfg_done) |-> $stable(s_reg.high_gain_select))
    else $error("high gain select changed after first write");
endmodule : cgu_top

//--- testbench/cgu_ext_src.sv
// External square-wave source model for the oscillator pin of the clock unit.
// Assumes the block samples the pin synchronously to ref_clk.
`timescale 1ns/1ps
module cgu_ext_src
#(
  parameter int HALF = 40
)
(
  input  wire logic ref_clk,
  input  wire logic run,
  output logic      ext_ref_in
);
  int cnt;
  // A removed source stands still at low rather than holding a half phase.
  always_ff @(posedge ref_clk) begin
    if (!run) begin
      cnt <= 0;
      ext_ref_in <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      ext_ref_in <= ~ext_ref_in;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : cgu_ext_src

//--- testbench/cgu_top_tb.sv
// Self-checking bench for the clock generation unit: register tasks and clock counters.
// Assumes the external source model drives the oscillator pin.
`timescale 1ns/1ps
module cgu_top_tb
  import cgu_pkg::*;
;
  logic        ref_clk, rst, stop_req, ext_run, ext_ref_in;
  cgu_bus_t    bus_q;
  logic [15:0] bus_rdata, v, saved;
  cgu_clk_t    clocks, prev;
  logic        osc_high_gain, osc_high_range, osc_enable, loss_reset_req, loss_irq;
  int          num_errors = 0, n_checks = 0, cyc = 0, a, b, c, d;
  int          n_out = 0, n_loop = 0, n_dbg = 0, n_ffe = 0, n_lrr = 0, n_erc = 0;

  cgu_top DUT (.ref_clk(ref_clk), .rst(rst), .bus(bus_q), .bus_rdata(bus_rdata), .ext_ref_in(ext_ref_in),
    .stop_req(stop_req), .clocks(clocks), .osc_high_gain(osc_high_gain), .osc_high_range(osc_high_range),
    .osc_enable(osc_enable), .loss_reset_req(loss_reset_req), .loss_irq(loss_irq));
  cgu_ext_src #(.HALF(40)) ext_src (.ref_clk(ref_clk), .run(ext_run), .ext_ref_in(ext_ref_in));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------------
  // Edge counters and hang guard
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    n_out += int'(clocks.clock_gen_output !== prev.clock_gen_output);
    n_loop += int'(clocks.loop_multiplied_clock !== prev.loop_multiplied_clock);
    n_dbg += int'(clocks.debug_local_clock !== prev.debug_local_clock);
    n_ffe += int'(clocks.fixed_freq_enable === 1'b1);
    n_erc += int'(clocks.external_reference_clock !== prev.external_reference_clock);
    n_lrr += int'(loss_reset_req === 1'b1);
    prev = clocks;
    if (cyc == 80000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic near(input int got, input int exp, input int tol);
    n_checks++;
    if (got < exp - tol || got > exp + tol) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : near
  task automatic wr(input logic [3:0] ad, input logic [15:0] dt);
    bus_q <= '{addr: ad, wdata: dt, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_q.wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [3:0] ad, output logic [15:0] dt);
    bus_q <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_q.rd <= 1'b0;
    #1 dt = bus_rdata;
    @(posedge ref_clk);
  endtask : rd
  task automatic rchk(input logic [3:0] ad, input logic [15:0] exp);
    rd(ad, v);
    check(v, exp);
  endtask : rchk
  // Polls status until all bits of the mask are set; the read count bounds the wait.
  task automatic poll(input logic [15:0] m, input int lim);
    for (int i = 0; i < lim; i++) begin
      rd(ADDR_STAT, v);
      if ((v & m) === m) break;
    end
    check(v & m, m);
  endtask : poll
  task automatic window(input int n, output int o, output int l, output int g, output int f);
    #1;
    o = n_out;
    l = n_loop;
    g = n_dbg;
    f = n_ffe;
    repeat (n) @(posedge ref_clk);
    #1;
    o = n_out - o;
    l = n_loop - l;
    g = n_dbg - g;
    f = n_ffe - f;
    @(posedge ref_clk);
  endtask : window
  task automatic rti_period(output int n);
    logic s;
    #1;
    for (int k = 0; k < 2; k++) begin
      s = clocks.rti_clock;
      n = 0;
      while (clocks.rti_clock === s && n < 600) begin
        #20;
        n++;
      end
    end
    @(posedge ref_clk);
  endtask : rti_period
  task automatic do_reset();
    rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
  endtask : do_reset
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    stop_req = 1'b0;
    ext_run = 1'b0;
    bus_q = '0;
    do_reset();
    rchk(ADDR_MULT, 16'h0020);
    rchk(ADDR_DIV, 16'h0000);
    rchk(ADDR_FILT, 16'h4000);
    rchk(ADDR_STAT, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rchk(4'hF, 16'h0000);
    window(205, a, b, c, d);
    near(a, 51, 3);
    near(c, 68, 2);
    rti_period(a);
    near(a, 205, 0);
    wr(ADDR_TRIM, 16'h0005);
    rti_period(a);
    rti_period(a);
    near(a, 210, 0);
    wr(ADDR_FILT, 16'h6000);
    window(205, a, b, c, d);
    near(a, 77, 3);
    // A multiplier of 40 keeps the loop target inside the oscillator's range with the trimmed reference.
    wr(ADDR_MULT, 16'h0028);
    wr(ADDR_CTRL, 16'h0001);
    poll(16'h0001, 5000);
    window(840, a, b, c, d);
    near(b, 160, 6);
    near(a, 160, 6);
    // Each divider step is given time to settle, since a new setting applies to an output phase already in progress.
    for (int n = 1; n < 8; n++) begin
      wr(ADDR_DIV, 16'(n));
      window(300, a, b, c, d);
      window(840, a, b, c, d);
      near(a, 160 >> n, 5);
    end
    stop_req <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rd(ADDR_FILT, saved);
    rd(ADDR_STAT, v);
    check(v & 16'h0020, 16'h0020);
    window(200, a, b, c, d);
    near(a, 0, 0);
    rchk(ADDR_FILT, saved);
    stop_req <= 1'b0;
    do_reset();
    wr(ADDR_CTRL, 16'h000E);
    repeat (50) @(posedge ref_clk);
    rd(ADDR_STAT, v);
    check(v & 16'h0012, 16'h0000);
    check({15'h0000, osc_enable}, 16'h0001);
    ext_run <= 1'b1;
    poll(16'h0002, 300);
    poll(16'h0010, 300);
    window(800, a, b, c, d);
    near(d, 10, 1);
    near(a, 20, 1);
    b = n_erc;
    repeat (800) @(posedge ref_clk);
    near(n_erc - b, 20, 1);
    wr(ADDR_CTRL, 16'h0003);
    check({14'h0000, osc_high_gain, osc_high_range}, 16'h0003);
    poll(16'h0001, 3000);
    ext_run <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(ADDR_FILT, saved);
    poll(16'h0008, 1500);
    check({15'h0000, loss_irq}, 16'h0001);
    check(v & 16'h0002, 16'h0000);
    rchk(ADDR_FILT, saved);
    check(16'(n_lrr), 16'h0000);
    wr(ADDR_STAT, 16'h000C);
    wr(ADDR_CTRL, 16'h0023);
    ext_run <= 1'b1;
    poll(16'h0002, 300);
    ext_run <= 1'b0;
    poll(16'h0008, 1500);
    check({15'h0000, loss_irq}, 16'h0000);
    check(16'(n_lrr != 0), 16'h0001);
    tally_and_finish();
  end
endmodule : cgu_top_tb
